//--- flr_cmd_props.sv
/* Port assertions for the command block.
   Assumes one core clock domain; bound to the top module. */
`timescale 1ns/1ps
`default_nettype none
module flr_cmd_props
  import flr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic individual_protect_select_in,
  input wire logic legacy_protect_in,
  input wire logic sig_done_in,
  input wire logic sig_match_in,
  input wire logic serial_oe_out,
  input wire logic write_enable_latch_out,
  input wire logic busy_out,
  input wire logic write_protected_out,
  input wire logic volatile_clear_out,
  input wire logic [7:0] replay_protected_counter_status_out,
  input wire flr_replay_protected_counter_req_t replay_protected_counter_req_out,
  input wire logic replay_protected_counter_req_valid_out,
  input wire logic [NUM_COUNTERS-1:0] root_key_written_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [TMR_W-1:0] cnt_q;
  logic srst_q;
  logic hup_q;
  wire sig_ok = sig_done_in && sig_match_in && busy_out;
  wire sig_bad = sig_done_in && !sig_match_in && busy_out;
  wire is_hup = replay_protected_counter_req_out.cmd_type == EXT_HMAC_UPDATE;
  wire restart = replay_protected_counter_req_valid_out || volatile_clear_out;
  // One counter times both long busy periods; each starts it afresh.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      srst_q <= 1'b0;
      hup_q <= 1'b0;
    end else begin
      cnt_q <= restart ? '0 : cnt_q + 1'b1;
      srst_q <= volatile_clear_out || (srst_q && !replay_protected_counter_req_valid_out);
      hup_q <= !restart && (hup_q || (sig_ok && is_hup));
    end
  end
  sequence s_root_ok;
    sig_ok && replay_protected_counter_req_out.cmd_type == EXT_ROOT_KEY;
  endsequence
  sequence s_posted(logic [7:0] code);
    ##[1:2] (replay_protected_counter_status_out == code && !busy_out);
  endsequence
  a_legacy_high: assert property ((!individual_protect_select_in && legacy_protect_in) [*3]
    |-> write_protected_out) else $error("protect not following legacy high");
  a_legacy_low: assert property ((!individual_protect_select_in && !legacy_protect_in) [*3]
    |-> !write_protected_out) else $error("protect not following legacy low");
  a_oe_idle: assert property (cs_n_in [*5] |-> !serial_oe_out)
    else $error("output driven while deselected");
  a_clear_pulse: assert property (volatile_clear_out |=> !volatile_clear_out)
    else $error("volatile clear too long");
  a_clear_state: assert property (volatile_clear_out |-> ##[0:1] (busy_out &&
    !write_enable_latch_out)) else $error("reset left latch or not busy");
  a_reset_length: assert property ($fell(busy_out) && srst_q |-> cnt_q >= RST_CYCLES - 3
    && cnt_q <= RST_CYCLES + 3) else $error("reset busy length wrong");
  a_req_pulse: assert property (replay_protected_counter_req_valid_out |=> !replay_protected_counter_req_valid_out && busy_out)
    else $error("request not a pulse under busy");
  a_root_ok: assert property (s_root_ok |-> s_posted(ST_CODE_OK))
    else $error("root write success not posted");
  a_sig_error: assert property (sig_bad && !is_hup |-> s_posted(ST_CODE_ERR_SIG))
    else $error("signature error not posted");
  a_hmac_sig_err: assert property (sig_bad && is_hup |=>
    (replay_protected_counter_status_out == ST_CODE_ERR_SIG && busy_out)) else $error("key update error wrong");
  a_key_cause: assert property ($changed(root_key_written_out) |-> $past(sig_ok)
    || $past(sig_ok, 2)) else $error("root state changed without signature");
  a_hmac_length: assert property ($fell(busy_out) && hup_q |-> cnt_q >= HUPD_CYCLES - 3)
    else $error("key update busy too short");
endmodule : flr_cmd_props
bind flr_cmd_top flr_cmd_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .cs_n_in(cs_n_in), .individual_protect_select_in(individual_protect_select_in),
  .legacy_protect_in(legacy_protect_in), .sig_done_in(sig_done_in),
  .sig_match_in(sig_match_in), .serial_oe_out(serial_oe_out),
  .write_enable_latch_out(write_enable_latch_out), .busy_out(busy_out),
  .write_protected_out(write_protected_out), .volatile_clear_out(volatile_clear_out),
  .replay_protected_counter_status_out(replay_protected_counter_status_out), .replay_protected_counter_req_out(replay_protected_counter_req_out),
  .replay_protected_counter_req_valid_out(replay_protected_counter_req_valid_out), .root_key_written_out(root_key_written_out));
`default_nettype wire

//--- flr_cmd_top.sv
/*
 * SPI instruction handling for block locks, software reset and the first two
 * replay-protected counter commands. The pins are oversampled by the core clock.
 * Assumes the serial clock is well below a quarter of the core clock and that an
 * outside engine computes the keyed signatures and answers each request.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Individual-protect select chooses lock bits; otherwise legacy protect fields decide.
// - Lock bits are volatile and all set after power-up or any reset.
// - Lock byte goes out MSB first on falling edges; LSB 1 means locked.
// - Opcode 7Eh alone sets every lock bit.
// - Opcode 98h alone clears every lock bit.
// - Global lock and unlock are ignored unless the write enable latch is set.
// - Accepted reset aborts work and clears volatile bits, latch, suspend, params, wrap; here only when idle: clears latch, sets all lock bits.
// - Reset needs 66h directly followed by 99h; anything else disarms it.
// - Reset takes 30 us and no command is accepted meanwhile.
// - Root key write checks 64-byte payload, address range, uninitialized root key.
// - Root key write needs the truncated 224-bit signature to match.
// - Successful root key write posts success in counter status.
// - Root key tracking state is written last on success.
// - All-ones key only initializes an uninitialized counter, tracked separately.
// - Root key write never alters an already-initialized counter.
// - After a real root key write, further root writes are rejected; key unreadable.
// - HMAC update checks 40-byte payload, range, initialized counter, signature.
// - HMAC update reports busy for twice the advertised polling delay.
// - Failed HMAC update is not done and its error is posted.
module flr_cmd_top
  import flr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic serial_in,
  input wire logic individual_protect_select_in,
  input wire logic legacy_protect_in,
  input wire logic [LOCK_IDX_W-1:0] prot_block_in,
  input wire logic sig_done_in,
  input wire logic sig_match_in,
  output logic serial_out,
  output logic serial_oe_out,
  output logic write_enable_latch_out,
  output logic busy_out,
  output logic write_protected_out,
  output logic volatile_clear_out,
  output logic [7:0] replay_protected_counter_status_out,
  output flr_replay_protected_counter_req_t replay_protected_counter_req_out,
  output logic replay_protected_counter_req_valid_out,
  output logic counter_zero_out,
  output logic [NUM_COUNTERS-1:0] counter_initialized_state_out,
  output logic [NUM_COUNTERS-1:0] root_key_written_out,
  output logic [NUM_COUNTERS-1:0] hmac_key_valid_out
);
  typedef enum logic [1:0] {FS_IDLE, FS_WAIT_SIG, FS_HOLD, FS_RESET} flr_state_t;

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic [6:0] sh_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] byte_cnt_q;
  logic [7:0] opcode_q;
  logic [7:0] ext_q;
  logic [7:0] ctr_addr_q;
  logic [LOCK_IDX_W-1:0] lock_addr_q;
  logic key_ones_q;
  logic ignore_q;
  logic rst_armed_q;
  logic [7:0] tx_q;
  logic tx_active_q;
  logic lock_bit;
  flr_state_t state_q;
  logic [TMR_W-1:0] tmr_q;
  logic sig_ok_q;
  logic hupd_q;
  logic set_all_q;
  logic clr_all_q;

  // Only the second synchroniser stage is read by the logic.
  wire cs_n_s = sync2_q[0];
  wire sclk_s = sync2_q[1];
  wire din_s = sync2_q[2];
  wire sclk_rise = sclk_s && !sclk_prev_q && !cs_n_s;
  wire sclk_fall = !sclk_s && sclk_prev_q && !cs_n_s;
  wire cs_fall = !cs_n_s && cs_prev_q;
  wire cs_rise = cs_n_s && !cs_prev_q;
  wire [7:0] byte_in = {sh_q, din_s};
  wire byte_done = sclk_rise && (bit_cnt_q == 3'd7);
  wire [7:0] byte_cnt_inc = (byte_cnt_q == 8'hFF) ? byte_cnt_q : byte_cnt_q + 8'd1;
  wire exact_op = (byte_cnt_q == 8'd1) && (bit_cnt_q == 3'd0);
  wire frame_ok = cs_rise && !ignore_q;
  wire ctr_in_range = ctr_addr_q < 8'(NUM_COUNTERS);
  wire [1:0] ctr_idx = ctr_addr_q[1:0];
  wire root_done = root_key_written_out[ctr_idx];
  wire mc_done = counter_initialized_state_out[ctr_idx];
  wire is_root = ext_q == EXT_ROOT_KEY;
  wire is_hupd = ext_q == EXT_HMAC_UPDATE;
  wire [7:0] want_bytes = is_root ? ROOT_KEY_BYTES : HMAC_UPD_BYTES;
  wire size_ok = (byte_cnt_q == want_bytes) && (bit_cnt_q == 3'd0);
  wire state_ok = is_root ? !root_done : mc_done;
  wire replay_protected_counter_frame = frame_ok && (opcode_q == OP_REPLAY_PROTECTED_COUNTER);
  wire [7:0] chk_code = !(is_root || is_hupd) ? ST_CODE_ERR_CMD :
                        !size_ok ? ST_CODE_ERR_SIZE :
                        !ctr_in_range ? ST_CODE_ERR_ADDR :
                        !state_ok ? ST_CODE_ERR_STATE : ST_CODE_NONE;
  wire do_glock = frame_ok && exact_op && opcode_q == OP_GLOBAL_LOCK && write_enable_latch_out;
  wire do_gunlock = frame_ok && exact_op && opcode_q == OP_GLOBAL_UNLOCK && write_enable_latch_out;
  wire do_reset = frame_ok && exact_op && opcode_q == OP_RESET && rst_armed_q;
  wire sig_fin = (state_q == FS_WAIT_SIG) && sig_done_in;
  wire hold_fin = (state_q == FS_HOLD) && (tmr_q == '0);
  wire root_commit = sig_fin && sig_match_in && !hupd_q;
  // Outside a lock query the read port follows the reported block again, so the
  // protect output does not stay stuck on the last queried address.
  wire rd_lock_sel = (opcode_q == OP_READ_LOCK) && !cs_n_s;
  wire [LOCK_IDX_W-1:0] mem_idx = rd_lock_sel ? lock_addr_q : prot_block_in;

  flr_lock_mem u_lock_mem (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_all_in(set_all_q),
    .clr_all_in(clr_all_q),
    .rd_idx_in(mem_idx),
    .rd_bit_out(lock_bit)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 3'b001;
      sync2_q <= 3'b001;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sync1_q <= {serial_in, sclk_in, cs_n_in};
      sync2_q <= sync1_q;
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // Instruction, address and payload capture on rising serial clock edges.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_q <= 7'h00;
      bit_cnt_q <= 3'd0;
      byte_cnt_q <= 8'h00;
      opcode_q <= 8'h00;
      ext_q <= 8'h00;
      ctr_addr_q <= 8'h00;
      lock_addr_q <= '0;
      key_ones_q <= 1'b1;
      ignore_q <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_q <= 3'd0;
      byte_cnt_q <= 8'h00;
      opcode_q <= 8'h00;
      key_ones_q <= 1'b1;
      ignore_q <= busy_out;
    end else if (sclk_rise) begin
      sh_q <= byte_in[6:0];
      bit_cnt_q <= bit_cnt_q + 3'd1;
      if (byte_done) begin
        byte_cnt_q <= byte_cnt_inc;
        if (byte_cnt_q == 8'd0) begin
          opcode_q <= byte_in;
        end
        if (byte_cnt_q == 8'd1) begin
          ext_q <= byte_in;
          lock_addr_q <= byte_in[LOCK_IDX_W-1:0];
        end
        if (byte_cnt_q == 8'd2) begin
          ctr_addr_q <= byte_in;
        end
        if (byte_cnt_q >= KEY_FIRST_BYTE && byte_cnt_q <= KEY_LAST_BYTE
            && byte_in != ALL_ONES_BYTE) begin
          key_ones_q <= 1'b0;
        end
      end
    end
  end

  // Lock byte read-out on falling edges, repeated while chip select stays low.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_q <= 8'h00;
      tx_active_q <= 1'b0;
      serial_out <= 1'b0;
      serial_oe_out <= 1'b0;
    end else if (cs_n_s) begin
      tx_active_q <= 1'b0;
      serial_oe_out <= 1'b0;
    end else if (byte_done && byte_cnt_q == ADDR_LAST_BYTE
                 && opcode_q == OP_READ_LOCK && !ignore_q) begin
      tx_q <= {LOCK_BYTE_HI, lock_bit};
      tx_active_q <= 1'b1;
    end else if (sclk_fall && tx_active_q) begin
      serial_out <= tx_q[7];
      serial_oe_out <= 1'b1;
      tx_q <= {tx_q[6:0], tx_q[7]};
    end
  end

  // Write enable latch, reset arming and global lock pulses.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_enable_latch_out <= 1'b0;
      rst_armed_q <= 1'b0;
      set_all_q <= 1'b0;
      clr_all_q <= 1'b0;
      volatile_clear_out <= 1'b0;
    end else begin
      set_all_q <= do_glock || do_reset;
      clr_all_q <= do_gunlock;
      volatile_clear_out <= do_reset;
      if (do_reset) begin
        write_enable_latch_out <= 1'b0;
      end else if (frame_ok && exact_op && opcode_q == OP_WRITE_ENABLE) begin
        write_enable_latch_out <= 1'b1;
      end else if (frame_ok && (opcode_q == OP_WRITE_DISABLE || do_glock || do_gunlock)) begin
        write_enable_latch_out <= 1'b0;
      end
      if (frame_ok && byte_cnt_q != 8'd0) begin
        rst_armed_q <= exact_op && opcode_q == OP_RESET_ENABLE;
      end
    end
  end

  // Command sequencing: signature wait, busy hold and reset recovery.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= FS_IDLE;
      tmr_q <= '0;
      sig_ok_q <= 1'b0;
      hupd_q <= 1'b0;
      busy_out <= 1'b0;
      replay_protected_counter_status_out <= ST_CODE_NONE;
      replay_protected_counter_req_out <= '0;
      replay_protected_counter_req_valid_out <= 1'b0;
    end else begin
      replay_protected_counter_req_valid_out <= 1'b0;
      case (state_q)
        FS_IDLE: begin
          if (do_reset) begin
            state_q <= FS_RESET;
            tmr_q <= TMR_W'(RST_CYCLES - 1);
            busy_out <= 1'b1;
          end else if (replay_protected_counter_frame) begin
            if (chk_code != ST_CODE_NONE) begin
              replay_protected_counter_status_out <= chk_code;
            end else begin
              state_q <= FS_WAIT_SIG;
              hupd_q <= is_hupd;
              busy_out <= 1'b1;
              replay_protected_counter_req_out <= '{cmd_type: ext_q, ctr_addr: ctr_addr_q};
              replay_protected_counter_req_valid_out <= 1'b1;
              tmr_q <= TMR_W'(HUPD_CYCLES - 1);
            end
          end
        end
        FS_WAIT_SIG: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - TMR_W'(1);
          end
          if (sig_done_in) begin
            sig_ok_q <= sig_match_in;
            if (!sig_match_in) begin
              replay_protected_counter_status_out <= ST_CODE_ERR_SIG;
            end
            if (hupd_q) begin
              state_q <= FS_HOLD;
            end else begin
              state_q <= FS_IDLE;
              busy_out <= 1'b0;
              if (sig_match_in) begin
                replay_protected_counter_status_out <= ST_CODE_OK;
              end
            end
          end
        end
        FS_HOLD: begin
          if (hold_fin) begin
            state_q <= FS_IDLE;
            busy_out <= 1'b0;
            if (sig_ok_q) begin
              replay_protected_counter_status_out <= ST_CODE_OK;
            end
          end else begin
            tmr_q <= tmr_q - TMR_W'(1);
          end
        end
        FS_RESET: begin
          if (tmr_q == '0) begin
            state_q <= FS_IDLE;
            busy_out <= 1'b0;
          end else begin
            tmr_q <= tmr_q - TMR_W'(1);
          end
        end
        default: begin
          state_q <= FS_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Counter tracking. The root key itself is never stored where an instruction reads it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      root_key_written_out <= '0;
      counter_initialized_state_out <= '0;
      hmac_key_valid_out <= '0;
      counter_zero_out <= 1'b0;
      write_protected_out <= 1'b1;
    end else begin
      counter_zero_out <= 1'b0;
      if (root_commit && key_ones_q && !mc_done) begin
        counter_initialized_state_out[ctr_idx] <= 1'b1;
        counter_zero_out <= 1'b1;
      end
      if (root_commit && !key_ones_q) begin
        root_key_written_out[ctr_idx] <= 1'b1;
        if (!mc_done) begin
          counter_initialized_state_out[ctr_idx] <= 1'b1;
          counter_zero_out <= 1'b1;
        end
      end
      if (hold_fin && sig_ok_q) begin
        hmac_key_valid_out[ctr_idx] <= 1'b1;
      end
      write_protected_out <= individual_protect_select_in ? lock_bit : legacy_protect_in;
    end
  end
endmodule : flr_cmd_top
`default_nettype wire

//--- flr_lock_mem.sv
/*
 * Volatile per-block lock bits with global set and clear and a registered read port.
 * Assumes set and clear are one-cycle pulses from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module flr_lock_mem
  import flr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic set_all_in,
  input wire logic clr_all_in,
  input wire logic [LOCK_IDX_W-1:0] rd_idx_in,
  output logic rd_bit_out
);
  logic [LOCK_DEPTH-1:0] lock_q;

  genvar gi;
  generate
    for (gi = 0; gi < LOCK_DEPTH; gi = gi + 1) begin : g_lock
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          lock_q[gi] <= 1'b1;
        end else if (set_all_in) begin
          lock_q[gi] <= 1'b1;
        end else if (clr_all_in) begin
          lock_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_bit_out <= 1'b1;
    end else begin
      rd_bit_out <= lock_q[rd_idx_in];
    end
  end
endmodule : flr_lock_mem
`default_nettype wire

//--- flr_pkg.sv
/*
 * Shared constants and types for the flash lock, reset and counter command block.
 * Assumes a 20 MHz core clock and an SPI mode 0/3 controller on the far side.
 */
package flr_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int LOCK_IDX_W = 8;
  localparam int LOCK_DEPTH = 256;
  localparam int NUM_COUNTERS = 4;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_LOCK = 8'h3D;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_REPLAY_PROTECTED_COUNTER = 8'h9B;
  localparam logic [7:0] EXT_ROOT_KEY = 8'h00;
  localparam logic [7:0] EXT_HMAC_UPDATE = 8'h01;
  localparam logic [7:0] ROOT_KEY_BYTES = 8'd64;
  localparam logic [7:0] HMAC_UPD_BYTES = 8'd40;
  localparam logic [7:0] KEY_FIRST_BYTE = 8'd4;
  localparam logic [7:0] KEY_LAST_BYTE = 8'd35;
  localparam logic [7:0] ADDR_LAST_BYTE = 8'd3;
  localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
  localparam logic [6:0] LOCK_BYTE_HI = 7'h00;
  // Counter status codes: one distinct code per outcome.
  localparam logic [7:0] ST_CODE_NONE = 8'h00;
  localparam logic [7:0] ST_CODE_OK = 8'h80;
  localparam logic [7:0] ST_CODE_ERR_SIZE = 8'h01;
  localparam logic [7:0] ST_CODE_ERR_ADDR = 8'h02;
  localparam logic [7:0] ST_CODE_ERR_STATE = 8'h04;
  localparam logic [7:0] ST_CODE_ERR_SIG = 8'h08;
  localparam logic [7:0] ST_CODE_ERR_CMD = 8'h10;
  // Reset recovery time and counter polling delay, in microseconds.
  localparam int T_RST_US = 30;
  localparam int T_POLL_US = 50;
  localparam int RST_CYCLES = T_RST_US * (CLK_HZ / 1_000_000);
  localparam int HUPD_CYCLES = 2 * T_POLL_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W = 12;

  typedef struct packed {
    logic [7:0] cmd_type;
    logic [7:0] ctr_addr;
  } flr_replay_protected_counter_req_t;
endpackage : flr_pkg

//--- flr_spi_host.sv
/* Behavioural SPI controller that frames commands for the block.
   Assumes mode 0 timing, link edges placed on falling core clock edges. */
`timescale 1ns/1ps
`default_nettype none
module flr_spi_host (
  input wire logic clk_in,
  input wire logic miso_in,
  input wire logic miso_oe_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  // The link clock stands low between frames.
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b1;
  end
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask : half
  task automatic frame(input logic [7:0] q[$], input int rd, output logic [7:0] r);
    int i;
    int b;
    cs_n_out = 1'b0;
    for (i = 0; i < q.size() + rd; i++) begin
      for (b = 7; b >= 0; b--) begin
        mosi_out = (i < q.size()) ? q[i][b] : ~mosi_out;
        half();
        sclk_out = 1'b1;
        half();
        // Sampled late in the high phase; a floating output reads unknown.
        if (i >= q.size()) r[b] = miso_oe_in ? miso_in : 1'bx;
        sclk_out = 1'b0;
      end
    end
    half();
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (8) @(negedge clk_in);
  endtask : frame
endmodule : flr_spi_host
`default_nettype wire

//--- test_flr_cmd_top.sv
/* Self-checking bench for the command block.
   Assumes the controller model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_flr_cmd_top
  import flr_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ips = 1'b1;
  logic legacy = 1'b1;
  logic [7:0] blk = 8'h00;
  logic sig_done_in = 1'b0;
  logic sig_match_in = 1'b0;
  wire logic cs_n_in, sclk_in, serial_in;
  logic serial_out, serial_oe_out, write_enable_latch, busy, wp;
  logic [7:0] st, got, ee, r;
  flr_replay_protected_counter_req_t rq;
  logic rqv;
  logic [3:0] ciz, rkw, hkv;
  int num_errors = 0;
  int tests_run = 0;
  int zc = 0;
  logic cz;
  logic [7:0] exp_q[$];
  logic [7:0] q[$];
  event ev;
  always #25 clk_in = ~clk_in;
  flr_cmd_top dut (.clk_in, .rst_n_in, .cs_n_in, .sclk_in, .serial_in,
    .individual_protect_select_in(ips), .legacy_protect_in(legacy), .prot_block_in(blk),
    .sig_done_in, .sig_match_in, .serial_out, .serial_oe_out, .write_enable_latch_out(write_enable_latch),
    .busy_out(busy), .write_protected_out(wp), .volatile_clear_out(), .replay_protected_counter_status_out(st),
    .replay_protected_counter_req_out(rq), .replay_protected_counter_req_valid_out(rqv), .counter_zero_out(cz),
    .counter_initialized_state_out(ciz), .root_key_written_out(rkw), .hmac_key_valid_out(hkv));
  flr_spi_host h (.clk_in, .miso_in(serial_out), .miso_oe_in(serial_oe_out),
    .cs_n_out(cs_n_in), .sclk_out(sclk_in), .mosi_out(serial_in));
  // The signature engine answers after a random delay, short or long.
  always @(posedge rqv) begin
    repeat (1 + $urandom % 40) @(negedge clk_in);
    sig_done_in = 1'b1;
    @(negedge clk_in);
    sig_done_in = 1'b0;
  end
  // Counts counter zeroing pulses; each one lasts a single core cycle.
  always @(negedge clk_in) if (cz === 1'b1) zc++;
  always @(ev) begin
    ee = exp_q.pop_front();
    `CHK(got, ee)
  end
  task note(input logic [7:0] e, input logic [7:0] a);
    exp_q.push_back(e);
    got = a;
    ->ev;
    #1;
  endtask : note
  task summarize();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task wait_idle();
    int i;
    for (i = 0; i < 2500 && busy !== 1'b0; i++) @(negedge clk_in);
    if (i == 2500) begin
      num_errors++;
      $display("BAD %0t busy stuck", $time);
      summarize();
    end
  endtask : wait_idle
  task cmd(input logic [7:0] b);
    q = '{b};
    h.frame(q, 0, r);
  endtask : cmd
  task rdlock(input logic [7:0] i, input logic l);
    q = '{OP_READ_LOCK, i, 8'($urandom), 8'($urandom)};
    h.frame(q, 1, r);
    note({7'h00, l}, r);
  endtask : rdlock
  task replay_protected_counter(input logic [7:0] t, a, input int n, input logic ones, m, input logic [7:0] e);
    int k;
    sig_match_in = m;
    q = '{OP_REPLAY_PROTECTED_COUNTER, t, a, 8'h00};
    for (k = 4; k < n; k++) q.push_back((ones && k <= KEY_LAST_BYTE) ? 8'hFF : 8'($urandom));
    h.frame(q, 0, r);
    wait_idle();
    note(e, st);
  endtask : replay_protected_counter
  task tend(input string s);
    $display("test %s done", s);
  endtask : tend
  initial begin
    blk = 8'($urandom(32'h601a5c72));
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rdlock(blk, 1'b1);
    note(8'h01, {7'h00, wp});
    ips = 1'b0;
    legacy = 1'b0;
    repeat (4) @(negedge clk_in);
    note(8'h00, {7'h00, wp});
    legacy = 1'b1;
    repeat (4) @(negedge clk_in);
    note(8'h01, {7'h00, wp});
    ips = 1'b1;
    tend("protect");
    cmd(OP_GLOBAL_UNLOCK);
    rdlock(blk, 1'b1);
    cmd(OP_WRITE_ENABLE);
    note(8'h01, {7'h00, write_enable_latch});
    cmd(OP_GLOBAL_UNLOCK);
    note(8'h00, {7'h00, write_enable_latch});
    rdlock(blk, 1'b0);
    note(8'h00, {7'h00, wp});
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GLOBAL_LOCK);
    rdlock(blk, 1'b1);
    tend("global");
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GLOBAL_UNLOCK);
    cmd(OP_RESET_ENABLE);
    cmd(OP_WRITE_ENABLE);
    cmd(OP_RESET);
    note(8'h00, {7'h00, busy});
    rdlock(blk, 1'b0);
    wait_idle();
    cmd(OP_RESET_ENABLE);
    cmd(OP_RESET);
    note(8'h01, {7'h00, busy});
    note(8'h00, {7'h00, write_enable_latch});
    cmd(OP_WRITE_ENABLE);
    wait_idle();
    note(8'h00, {7'h00, write_enable_latch});
    rdlock(blk, 1'b1);
    tend("reset");
    replay_protected_counter(EXT_ROOT_KEY, 8'h00, 40, 1'b0, 1'b1, ST_CODE_ERR_SIZE);
    replay_protected_counter(EXT_ROOT_KEY, 8'(NUM_COUNTERS), 64, 1'b0, 1'b1, ST_CODE_ERR_ADDR);
    replay_protected_counter(EXT_ROOT_KEY, 8'h00, 64, 1'b0, 1'b0, ST_CODE_ERR_SIG);
    replay_protected_counter(EXT_ROOT_KEY, 8'h00, 64, 1'b0, 1'b1, ST_CODE_OK);
    note(8'h11, {rkw, ciz});
    replay_protected_counter(EXT_ROOT_KEY, 8'h00, 64, 1'b0, 1'b1, ST_CODE_ERR_STATE);
    replay_protected_counter(EXT_ROOT_KEY, 8'h01, 64, 1'b1, 1'b1, ST_CODE_OK);
    note(8'h13, {rkw, ciz});
    replay_protected_counter(EXT_ROOT_KEY, 8'h01, 64, 1'b1, 1'b1, ST_CODE_OK);
    note(8'h13, {rkw, ciz});
    note(8'h02, 8'(zc));
    tend("root");
    replay_protected_counter(EXT_HMAC_UPDATE, 8'h02, 40, 1'b0, 1'b1, ST_CODE_ERR_STATE);
    replay_protected_counter(EXT_HMAC_UPDATE, 8'h00, 64, 1'b0, 1'b1, ST_CODE_ERR_SIZE);
    replay_protected_counter(EXT_HMAC_UPDATE, 8'h00, 40, 1'b0, 1'b0, ST_CODE_ERR_SIG);
    replay_protected_counter(EXT_HMAC_UPDATE, 8'h00, 40, 1'b0, 1'b1, ST_CODE_OK);
    note(8'h01, {4'h0, hkv});
    replay_protected_counter(8'h02, 8'h00, 40, 1'b0, 1'b1, ST_CODE_ERR_CMD);
    tend("hmac");
    summarize();
  end
endmodule : test_flr_cmd_top
`default_nettype wire
